// *** common/regfile_decode_params.svh ***
// Constants for the register file and program memory address decoder
`ifndef REGFILE_DECODE_PARAMS_SVH
`define REGFILE_DECODE_PARAMS_SVH

// ----------------------------------------
// Address widths
// ----------------------------------------
`define RF_ADDR_W 12
`define RF_SPACE_BYTES 4096
`define PM_ADDR_W 16
`define PM_SPACE_BYTES 65536

// ----------------------------------------
// Region boundaries
// ----------------------------------------
`define RF_RAM_BASE 12'h000
`define RF_CTRL_BASE 12'hf00
`define RF_CTRL_TOP 12'hfff
`define RF_CTRL_BYTES 256

// ----------------------------------------
// Size limits and defaults
// ----------------------------------------
`define RAM_MIN_BYTES 256
`define RAM_MAX_BYTES 1024
`define FLASH_MIN_BYTES 1024
`define FLASH_MAX_BYTES 8192

// ----------------------------------------
// Read value for undefined locations
// ----------------------------------------
`define RF_UNDEF_DATA 8'h00

`endif

// *** common/regfile_decode_pkg.sv ***
// Types shared by the register file decoder
`default_nettype none
package regfile_decode_pkg;
	// Region choice, exactly one per access
	typedef enum logic [1:0] {
		REGION_RAM = 2'h0,
		REGION_UNIMP = 2'h1,
		REGION_CTRL = 2'h3
	} region_t;
endpackage
`default_nettype wire

// *** rtl/rf_region_select.sv ***
// Combinational region select for a 12-bit register file address
`timescale 1ns/10ps
`default_nettype none
`include "regfile_decode_params.svh"

module rf_region_select #(
	parameter int RAM_BYTES = `RAM_MAX_BYTES
) (
	input wire logic [11:0] i_addr, // Register file byte address
	output regfile_decode_pkg::region_t o_region // Chosen region
);
	// ----------------------------------------
	// Boundary compare
	// ----------------------------------------
	localparam logic [12:0] RAM_END = 13'(RAM_BYTES);

	// The RAM must end below the control region, or the two would overlap
	if (RAM_BYTES < 1 || RAM_BYTES > `RF_CTRL_BASE) begin : g_size_chk
		$error("RAM size overlaps control region");
	end

	// Control region wins first; then RAM; everything else unimplemented
	always_comb begin
		if (i_addr >= `RF_CTRL_BASE) begin
			o_region = regfile_decode_pkg::REGION_CTRL;
		end else if ({1'b0, i_addr} < RAM_END) begin
			o_region = regfile_decode_pkg::REGION_RAM;
		end else begin
			o_region = regfile_decode_pkg::REGION_UNIMP;
		end
	end
endmodule // rf_region_select
`default_nettype wire

// *** rtl/regfile_address_decode.sv ***
// Register file and program memory address decode with on-chip RAM
// Operation
// - Decode 4096-byte, 12-bit register file space
// - Top 256 bytes F00-FFF are control
// - Reserved control reads return undefined data
// - RAM starts at address zero upward
// - RAM size parameter 256 B to 1 KB
// - Reads above RAM, below control: undefined
// - Writes above RAM, below control ignored
// - Sources read, destinations written, any register
// - Separate 64 KB, 16-bit program space
// - Flash 1 to 8 KB at bottom
`timescale 1ns/10ps
`default_nettype none
`include "regfile_decode_params.svh"

module regfile_address_decode #(
	parameter int RAM_BYTES = `RAM_MAX_BYTES, // On-chip RAM size
	parameter int FLASH_BYTES = `FLASH_MAX_BYTES // On-chip flash size
) (
	input wire logic i_clk, // System clock, 125 MHz
	input wire logic i_rst_b, // Asynchronous reset, active low
	input wire logic [11:0] i_rf_addr, // Register file byte address
	input wire logic i_rf_rd, // Read request, one cycle
	input wire logic i_rf_wr, // Write request, one cycle
	input wire logic [7:0] i_rf_wdata, // Write data
	output logic [7:0] o_rf_rdata, // Read data, valid with o_rf_rvalid
	output logic o_rf_rvalid, // Read answer pulse
	output logic o_sel_ram, // Access targets RAM
	output logic o_sel_ctrl, // Access targets control registers
	output logic o_sel_unimp, // Access targets unimplemented space
	output logic [7:0] o_ctrl_addr, // Offset inside control region
	output logic o_ctrl_rd, // Control read strobe
	output logic o_ctrl_wr, // Control write strobe
	output logic [7:0] o_ctrl_wdata, // Control write data
	input wire logic [7:0] i_ctrl_rdata, // Control read data, same cycle
	input wire logic [15:0] i_pm_addr, // Program memory byte address
	output logic o_pm_sel_flash, // Program address inside flash
	output logic o_pm_unimp // Program address above flash
);
	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Sizes are refused while the block is built, so a bad variant never runs
	// A RAM above 1 KB would cover part of the gap that software expects empty
	if (RAM_BYTES < `RAM_MIN_BYTES || RAM_BYTES > `RAM_MAX_BYTES) begin : g_ram_chk
		$error("RAM size out of range");
	end
	// Flash sits at the bottom of the program space and may not pass 8 KB
	if (FLASH_BYTES < `FLASH_MIN_BYTES || FLASH_BYTES > `FLASH_MAX_BYTES) begin : g_flash_chk
		$error("Flash size out of range");
	end

	// Index width; a 1 KB RAM needs 10 bits, a 256-byte one needs 8
	localparam int RAM_AW = $clog2(RAM_BYTES);
	localparam logic [16:0] FLASH_END = 17'(FLASH_BYTES);

	// ----------------------------------------
	// Region decode
	// ----------------------------------------
	regfile_decode_pkg::region_t region; // Region of current address

	rf_region_select #(
		.RAM_BYTES(RAM_BYTES)
	) u_sel (
		.i_addr(i_rf_addr),
		.o_region(region)
	);

	// Select lines come straight from the region; only one can be high
	// Control data must be valid in the cycle of the strobe; there is no wait state
	always_comb begin
		o_sel_ram = (region == regfile_decode_pkg::REGION_RAM);
		o_sel_ctrl = (region == regfile_decode_pkg::REGION_CTRL);
		o_sel_unimp = (region == regfile_decode_pkg::REGION_UNIMP);
		o_ctrl_addr = i_rf_addr[7:0];
		o_ctrl_rd = i_rf_rd && o_sel_ctrl;
		// Reserved control writes still pass; the CPU must avoid them
		o_ctrl_wr = i_rf_wr && o_sel_ctrl;
		o_ctrl_wdata = i_rf_wdata;
	end

	// Strobes follow the request only inside the top 256 bytes
	AST_CTRL_PASS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_addr[11:8] == 4'hf) |-> (o_ctrl_rd == i_rf_rd && o_ctrl_wr == i_rf_wr))
		else $error("control strobe lost");

	AST_CTRL_QUIET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_addr[11:8] != 4'hf) |-> (!o_ctrl_rd && !o_ctrl_wr))
		else $error("control strobe outside control region");

	// ----------------------------------------
	// On-chip RAM
	// ----------------------------------------
	logic [7:0] ram [RAM_BYTES]; // Register file storage
	logic ram_we; // RAM write enable
	logic [RAM_AW-1:0] ram_idx; // RAM word index

	always_comb begin
		// Non-power-of-two sizes are fine: the select already bounds the index
		ram_idx = i_rf_addr[RAM_AW-1:0];
		// Writes outside RAM and control are simply dropped
		ram_we = i_rf_wr && o_sel_ram;
	end

	// Storage has no reset, like a real SRAM
	always_ff @(posedge i_clk) begin
		if (ram_we) begin
			ram[ram_idx] <= i_rf_wdata;
		end
	end

	// A RAM write lands in the addressed byte at the edge that takes it
	AST_RAM_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_wr && o_sel_ram) |=> (ram[$past(ram_idx)] == $past(i_rf_wdata)))
		else $error("RAM write lost");

	// A gap write must leave the RAM byte that shares its low index bits alone
	AST_GAP_NO_ALIAS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_wr && o_sel_unimp) |=> (ram[$past(ram_idx)] == $past(ram[ram_idx])))
		else $error("gap write changed RAM");

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] next_rf_rdata; // Next read data
	logic next_rf_rvalid; // Next read answer

	// Unimplemented reads give a fixed filler value; control reads, reserved or not, take i_ctrl_rdata
	// A read and a write of one byte in one cycle return the old byte,
	// because the array is read before the edge that stores the new one
	always_comb begin
		next_rf_rvalid = i_rf_rd;
		next_rf_rdata = o_rf_rdata;
		if (i_rf_rd) begin
			case (region)
				regfile_decode_pkg::REGION_RAM: next_rf_rdata = ram[ram_idx];
				regfile_decode_pkg::REGION_CTRL: next_rf_rdata = i_ctrl_rdata;
				default: next_rf_rdata = `RF_UNDEF_DATA;
			endcase
		end
	end

	// Register read answer one cycle after the request
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rf_rdata <= 8'h00;
			o_rf_rvalid <= 1'b0;
		end else begin
			o_rf_rdata <= next_rf_rdata;
			o_rf_rvalid <= next_rf_rvalid;
		end
	end

	// Every read gets exactly one answer pulse, and nothing else raises it
	AST_RVALID_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_rf_rd |=> o_rf_rvalid)
		else $error("read got no answer");

	AST_RVALID_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_rf_rd |=> !o_rf_rvalid)
		else $error("answer without a read");

	// Read data keeps the last answer between reads, so a slow consumer is safe
	AST_RDATA_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!i_rf_rd |=> $stable(o_rf_rdata))
		else $error("read data changed without a read");

	// ----------------------------------------
	// Program memory decode
	// ----------------------------------------
	// 16-bit space fully covers 64 KB; flash sits at the bottom
	// The unimplemented flag lets the fetch side catch a stray jump above flash
	always_comb begin
		o_pm_sel_flash = ({1'b0, i_pm_addr} < FLASH_END);
		o_pm_unimp = !o_pm_sel_flash;
	end

	// Program address zero always lands in flash, whatever the variant
	AST_FLASH_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_pm_addr == 16'h0000) |-> o_pm_sel_flash)
		else $error("program address zero not in flash");

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// Region checks watch the live address, so they cover idle cycles too
	AST_ONE_REGION: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$onehot({o_sel_ram, o_sel_ctrl, o_sel_unimp}))
		else $error("region select not one-hot");

	AST_CTRL_TOP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_sel_ctrl == (i_rf_addr[11:8] == 4'hf))
		else $error("control region mismatch");

	AST_RAM_BOUND: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_sel_ram == (32'(i_rf_addr) < RAM_BYTES))
		else $error("RAM bound mismatch");

	AST_RAM_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_addr == 12'h000) |-> o_sel_ram)
		else $error("address zero not RAM");

	AST_UNIMP_READ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_rd && o_sel_unimp) |=> (o_rf_rvalid && o_rf_rdata == `RF_UNDEF_DATA))
		else $error("unimplemented read value wrong");

	AST_UNIMP_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_sel_unimp |-> (!ram_we && !o_ctrl_wr))
		else $error("unimplemented write took effect");

	AST_RAM_RW: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		((i_rf_wr && o_sel_ram && !i_rf_rd) ##1 (i_rf_rd && !i_rf_wr
			&& $stable(i_rf_addr))) |=> (o_rf_rdata == $past(i_rf_wdata, 2)))
		else $error("RAM write then read mismatch");

	AST_CTRL_READ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(i_rf_rd && o_sel_ctrl) |=> (o_rf_rdata == $past(i_ctrl_rdata)))
		else $error("control read data wrong");

	AST_FLASH: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_pm_sel_flash == (32'(i_pm_addr) < FLASH_BYTES))
		else $error("flash select mismatch");
endmodule // regfile_address_decode
`default_nettype wire

// *** dv/ctrl_reg_model.sv ***
// Control register responder standing on the decoder's peripheral port
`timescale 1ns/10ps
`default_nettype none
module ctrl_reg_model (
	input wire logic [7:0] i_addr, // Offset inside control region
	input wire logic i_rd, // Control read strobe
	output logic [7:0] o_rdata // Read data, same cycle as strobe
);
	// Idle data is the inverse of the answer, so stale data never looks fresh
	always_comb begin
		if (i_rd) begin
			o_rdata = i_addr ^ 8'h5a;
		end else begin
			o_rdata = ~(i_addr ^ 8'h5a);
		end
	end
endmodule // ctrl_reg_model
`default_nettype wire

// *** dv/regfile_address_decode_tb.sv ***
// Self-checking testbench for the register file address decoder
`timescale 1ns/10ps
`default_nettype none
module regfile_address_decode_tb;
	// ------------------------------------
	// Stimulus and observed signals
	// ------------------------------------
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [11:0] addr = 12'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [15:0] pm_addr = 16'h0000;
	logic [7:0] rdata, c_addr, c_wdata, c_rdata;
	logic rvalid, s_ram, s_ctrl, s_unimp, c_rd, c_wr, pm_fl, pm_un;
	int failures = 0;
	int num_checks = 0;
	always #4 i_clk = ~i_clk; // 125 MHz
	// Smallest sizes, so the unimplemented gap is as wide as it gets
	regfile_address_decode #(.RAM_BYTES(256), .FLASH_BYTES(1024)) u_dut (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_rf_addr(addr), .i_rf_rd(rd),
		.i_rf_wr(wr), .i_rf_wdata(wdata), .o_rf_rdata(rdata), .o_rf_rvalid(rvalid),
		.o_sel_ram(s_ram), .o_sel_ctrl(s_ctrl), .o_sel_unimp(s_unimp),
		.o_ctrl_addr(c_addr), .o_ctrl_rd(c_rd), .o_ctrl_wr(c_wr),
		.o_ctrl_wdata(c_wdata), .i_ctrl_rdata(c_rdata), .i_pm_addr(pm_addr),
		.o_pm_sel_flash(pm_fl), .o_pm_unimp(pm_un));
	ctrl_reg_model u_ctrl (.i_addr(c_addr), .i_rd(c_rd), .o_rdata(c_rdata));
	// ------------------------------------
	// Shared tasks
	// ------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One request, driven at a falling edge and taken at the next rising edge
	task automatic access(input logic [11:0] a, input logic r, input logic w,
		input logic [7:0] d, input logic [2:0] sel);
		@(negedge i_clk);
		addr = a;
		rd = r;
		wr = w;
		wdata = d;
		#1;
		chk({13'h0, s_ram, s_ctrl, s_unimp}, {13'h0, sel});
		chk({6'h0, c_rd, c_wr, c_addr}, {6'h0, r & sel[1], w & sel[1], a[7:0]});
		chk({8'h0, c_wdata}, {8'h0, d});
		@(negedge i_clk);
		rd = 1'b0;
		wr = 1'b0;
		chk({15'h0, rvalid}, {15'h0, r});
	endtask
	// Read whose answer must arrive exactly one edge after it is taken
	task automatic rd_chk(input logic [11:0] a, input logic [2:0] sel, input logic [7:0] e);
		access(a, 1'b1, 1'b0, 8'h00, sel);
		chk({7'h0, rvalid, rdata}, {8'h01, e});
		@(negedge i_clk);
		chk({7'h0, rvalid, rdata}, {8'h00, e});
	endtask
	// ------------------------------------
	// Scenarios
	// ------------------------------------
	task automatic test_ram();
		access(12'h000, 1'b0, 1'b1, 8'ha5, 3'b100);
		access(12'h0ff, 1'b0, 1'b1, 8'h3c, 3'b100);
		rd_chk(12'h000, 3'b100, 8'ha5);
		rd_chk(12'h0ff, 3'b100, 8'h3c);
	endtask
	// Gap writes must not alias onto RAM through the low index bits
	task automatic test_gap();
		access(12'h100, 1'b0, 1'b1, 8'h77, 3'b001);
		access(12'heff, 1'b0, 1'b1, 8'h66, 3'b001);
		rd_chk(12'h100, 3'b001, 8'h00);
		rd_chk(12'heff, 3'b001, 8'h00);
		rd_chk(12'h000, 3'b100, 8'ha5);
		rd_chk(12'h0ff, 3'b100, 8'h3c);
	endtask
	// Write then read with no idle cycle, then a read and a write together
	task automatic test_wr_rd();
		@(negedge i_clk);
		addr = 12'h055;
		wr = 1'b1;
		wdata = 8'h96;
		@(negedge i_clk);
		wr = 1'b0;
		rd = 1'b1;
		@(negedge i_clk);
		chk({7'h0, rvalid, rdata}, {8'h01, 8'h96});
		wr = 1'b1;
		wdata = 8'h69;
		@(negedge i_clk);
		chk({7'h0, rvalid, rdata}, {8'h01, 8'h96});
		rd = 1'b0;
		wr = 1'b0;
		rd_chk(12'h055, 3'b100, 8'h69);
	endtask
	task automatic test_ctrl();
		rd_chk(12'hf00, 3'b010, 8'h5a);
		rd_chk(12'hfff, 3'b010, 8'ha5);
		// Only an implemented offset is written; reserved offsets are never stored to
		access(12'hf3c, 1'b0, 1'b1, 8'hc3, 3'b010);
	endtask
	task automatic test_pm();
		@(negedge i_clk);
		pm_addr = 16'h03ff;
		#1;
		chk({14'h0, pm_fl, pm_un}, 16'h0002);
		@(negedge i_clk);
		pm_addr = 16'h0400;
		#1;
		chk({14'h0, pm_fl, pm_un}, 16'h0001);
		@(negedge i_clk);
		pm_addr = 16'hffff;
		#1;
		chk({14'h0, pm_fl, pm_un}, 16'h0001);
	endtask
	// ------------------------------------
	// Verdict and main sequence
	// ------------------------------------
	task automatic complete_run();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard: every sequence is fixed length, so this bound is generous
	initial begin
		repeat (2000) @(posedge i_clk);
		failures++;
		complete_run();
	end
	initial begin
		repeat (5) @(negedge i_clk);
		chk({7'h0, rvalid, rdata}, 16'h0000);
		i_rst_b = 1'b1;
		test_ram();
		test_gap();
		test_wr_rd();
		test_ctrl();
		test_pm();
		complete_run();
	end
endmodule // regfile_address_decode_tb
`default_nettype wire
